// ### hdl/boot_loader_defs.svh
// constants of the node number and bit rate boot loader
// assumes a 10 MHz pclk and an 8-word setup table at the bottom of nonvolatile memory
`ifndef BOOT_LOADER_DEFS_SVH
`define BOOT_LOADER_DEFS_SVH

// ****************************************
// setup table layout
// ****************************************
`define SETUP_WORDS 8
`define IDX_MARK 3'h0
`define IDX_FLAGS 3'h1
`define IDX_NODE 3'h2
`define IDX_RATE 3'h3
`define IDX_LAST_NODE 3'h6
`define IDX_LAST_RATE 3'h7
`define IDX_LAST 3'h7
`define SETUP_MARK 16'ha5c3
`define FLAG_NODE_SEL 0
`define FLAG_RATE_SEL 1
`define STORED_BIT 15
`define NODE_SWITCHES 8'h00
`define NODE_MAX_CANOPEN 8'h7f
`define NODE_UNCONFIGURED 8'hff
`define RATE_CODE_DEFAULT 3'h4
`define SWITCH_CANOPEN 0

// ****************************************
// register offsets
// ****************************************
`define REG_STATUS 8'h00
`define REG_NODE 8'h04
`define REG_RATE 8'h08
`define REG_SERIAL_NODE 8'h0c
`define REG_RAM_BASE 8'h20
`define REG_RAM_TOP 8'h3c

// ****************************************
// timing
// ****************************************
`define SETTLE_CYCLES 3'h4

`endif

// ### hdl/boot_loader_pkg.sv
// types of the node number and bit rate boot loader
// assumes boot_loader_defs.svh for all numeric constants
package boot_loader_pkg;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {RATE_125K, RATE_250K, RATE_500K, RATE_1M} rate_t;
   typedef enum {ST_SETTLE, ST_LOAD_REQ, ST_LOAD_WAIT, ST_EVAL, ST_DECIDE, ST_RUN} boot_state_t;

endpackage : boot_loader_pkg

// ### hdl/setup_ram.sv
// working ram copy of the setup table
// assumes one writer and one reader on pclk
`timescale 1ns/100ps
module setup_ram (
   // clock
   input wire logic pclk,
   // write port
   input wire logic wr_en,
   input wire logic [2:0] wr_addr,
   input wire logic [15:0] wr_data,
   // read port, one cycle latency
   input wire logic [2:0] rd_addr,
   output logic [15:0] rd_data
);
   logic [15:0] mem [0:7];

   always_ff @(posedge pclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge pclk) begin
      rd_data <= mem[rd_addr];
   end
endmodule : setup_ram

// ### hdl/node_id_and_bitrate_boot_loader.sv
// power-on selection of node number and can bit rate, apb register view
// assumes a nonvolatile memory port answering with nv_ack, and identity switches on pins
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "boot_loader_defs.svh"
module node_id_and_bitrate_boot_loader (
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // identity switches
   input wire logic [7:0] identity_switch_bank,
   // nonvolatile memory
   output logic nv_rd,
   output logic nv_wr,
   output logic [2:0] nv_addr,
   output logic [15:0] nv_wdata,
   input wire logic nv_ack,
   input wire logic [15:0] nv_rdata,
   // layer-setting assignments from the network master
   input wire logic lss_node_valid,
   input wire logic [7:0] lss_node,
   input wire logic lss_rate_valid,
   input wire logic [1:0] lss_rate,
   // canopen command gate
   input wire logic cmd_valid,
   input wire logic cmd_is_lss,
   output logic cmd_accept,
   output logic tx_enable,
   output logic bootup_send,
   // selected configuration
   output logic [7:0] node_number,
   output boot_loader_pkg::rate_t can_rate,
   output logic canopen_mode,
   output logic non_configured,
   output logic boot_done
);
   import boot_loader_pkg::*;

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic node_ok(input logic [7:0] n, input logic canopen);
      node_ok = (n != `NODE_SWITCHES) && (!canopen || n <= `NODE_MAX_CANOPEN);
   endfunction : node_ok

   function automatic rate_t rate_decode(input logic [2:0] code);
      case (code)
         3'h0: rate_decode = RATE_125K;
         3'h1: rate_decode = RATE_250K;
         3'h3: rate_decode = RATE_1M;
         default: rate_decode = RATE_500K;
      endcase
   endfunction : rate_decode

   // ****************************************
   // switch synchroniser
   // ****************************************
   logic [7:0] sw_s1_reg, sw_s2_reg, sw_s3_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_s1_reg <= 8'h00;
         sw_s2_reg <= 8'h00;
         sw_s3_reg <= 8'h00;
      end else begin
         sw_s1_reg <= identity_switch_bank;
         sw_s2_reg <= sw_s1_reg;
         sw_s3_reg <= sw_s2_reg;
      end
   end

   // ****************************************
   // boot sequence
   // ****************************************
   boot_state_t state_reg;
   logic [2:0] settle_reg, idx_reg, eval_idx_reg;
   logic eval_pipe_reg;
   logic [15:0] mark_reg, flags_reg, tnode_reg, trate_reg, lnode_reg, lrate_reg;
   logic ram_we;
   logic [2:0] ram_waddr, ram_raddr;
   logic [15:0] ram_rdata;
   logic run;
   logic table_valid_reg;

   assign run = (state_reg == ST_RUN);
   assign ram_we = (state_reg == ST_LOAD_WAIT) && nv_ack;
   assign ram_waddr = idx_reg;
   assign ram_raddr = run ? paddr[4:2] : eval_idx_reg;

   setup_ram u_ram (
      .pclk(pclk),
      .wr_en(ram_we),
      .wr_addr(ram_waddr),
      .wr_data(nv_rdata),
      .rd_addr(ram_raddr),
      .rd_data(ram_rdata)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_SETTLE;
         settle_reg <= 3'h0;
         idx_reg <= 3'h0;
         eval_idx_reg <= 3'h0;
         eval_pipe_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_SETTLE: begin
               settle_reg <= settle_reg + 3'h1;
               if (settle_reg == `SETTLE_CYCLES) begin
                  state_reg <= ST_LOAD_REQ;
               end
            end
            ST_LOAD_REQ: state_reg <= ST_LOAD_WAIT;
            ST_LOAD_WAIT: begin
               if (nv_ack) begin
                  idx_reg <= idx_reg + 3'h1;
                  state_reg <= (idx_reg == `IDX_LAST) ? ST_EVAL : ST_LOAD_REQ;
               end
            end
            ST_EVAL: begin
               // decisions come from the ram copy, not the nonvolatile memory
               eval_pipe_reg <= 1'b1;
               eval_idx_reg <= eval_idx_reg + 3'h1;
               if (eval_pipe_reg && eval_idx_reg == 3'h0) begin
                  state_reg <= ST_DECIDE;
               end
            end
            ST_DECIDE: begin
               // wait for a stable switch reading: second and third stage agree
               if (sw_s2_reg == sw_s3_reg) begin
                  state_reg <= ST_RUN;
               end
            end
            ST_RUN: state_reg <= ST_RUN;
            default: state_reg <= ST_SETTLE;
         endcase
      end
   end

   // capture of table words one cycle after each ram read
   logic [2:0] cap_idx;
   assign cap_idx = eval_idx_reg - 3'h1;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mark_reg <= 16'h0000;
         flags_reg <= 16'h0000;
         tnode_reg <= 16'h0000;
         trate_reg <= 16'h0000;
         lnode_reg <= 16'h0000;
         lrate_reg <= 16'h0000;
      end else if (state_reg == ST_EVAL && eval_pipe_reg) begin
         case (cap_idx)
            `IDX_MARK: mark_reg <= ram_rdata;
            `IDX_FLAGS: flags_reg <= ram_rdata;
            `IDX_NODE: tnode_reg <= ram_rdata;
            `IDX_RATE: trate_reg <= ram_rdata;
            `IDX_LAST_NODE: lnode_reg <= ram_rdata;
            `IDX_LAST_RATE: lrate_reg <= ram_rdata;
            default: mark_reg <= mark_reg;
         endcase
      end
   end

   // ****************************************
   // node number and rate selection
   // ****************************************
   logic tvalid, node_from_table, rate_from_table;
   logic [7:0] sw_node, pick_node;
   rate_t pick_rate;
   logic serial_wr;
   logic [7:0] serial_node;

   assign tvalid = (mark_reg == `SETUP_MARK);
   assign node_from_table = tvalid && flags_reg[`FLAG_NODE_SEL];
   assign rate_from_table = tvalid && flags_reg[`FLAG_RATE_SEL];
   assign sw_node = {1'b0, sw_s3_reg[7:1]};

   always_comb begin
      if (node_from_table) begin
         pick_node = tnode_reg[7:0];
      end else if (lnode_reg[`STORED_BIT]) begin
         pick_node = lnode_reg[7:0];
      end else begin
         pick_node = `NODE_SWITCHES;
      end
      if (pick_node == `NODE_SWITCHES) begin
         pick_node = sw_node;
      end
      if (rate_from_table) begin
         pick_rate = rate_decode(trate_reg[2:0]);
      end else if (lrate_reg[`STORED_BIT]) begin
         pick_rate = rate_decode(lrate_reg[2:0]);
      end else begin
         pick_rate = rate_decode(`RATE_CODE_DEFAULT);
      end
   end

   logic lss_node_take, lss_rate_take, serial_take;
   assign lss_node_take = run && lss_node_valid && node_ok(lss_node, canopen_mode);
   assign lss_rate_take = run && lss_rate_valid;
   assign serial_take = serial_wr && node_ok(serial_node, canopen_mode);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         node_number <= `NODE_UNCONFIGURED;
         can_rate <= RATE_500K;
         canopen_mode <= 1'b0;
         non_configured <= 1'b0;
         boot_done <= 1'b0;
         table_valid_reg <= 1'b0;
      end else if (state_reg == ST_DECIDE && sw_s2_reg == sw_s3_reg) begin
         canopen_mode <= sw_s3_reg[`SWITCH_CANOPEN];
         table_valid_reg <= tvalid;
         can_rate <= pick_rate;
         boot_done <= 1'b1;
         if (sw_s3_reg[`SWITCH_CANOPEN] && pick_node > `NODE_MAX_CANOPEN) begin
            node_number <= `NODE_UNCONFIGURED;
            non_configured <= 1'b1;
         end else begin
            node_number <= pick_node;
         end
      end else if (run) begin
         if (serial_take) begin
            node_number <= serial_node;
            non_configured <= 1'b0;
         end else if (lss_node_take) begin
            node_number <= lss_node;
            non_configured <= 1'b0;
         end
         if (lss_rate_take) begin
            can_rate <= rate_t'(lss_rate);
         end
      end
   end

   // ****************************************
   // canopen gate
   // ****************************************
   logic booted_msg_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_accept <= 1'b0;
         tx_enable <= 1'b0;
         bootup_send <= 1'b0;
         booted_msg_reg <= 1'b0;
      end else begin
         cmd_accept <= run && cmd_valid && (!non_configured || cmd_is_lss);
         tx_enable <= run && !non_configured;
         bootup_send <= run && !non_configured && !booted_msg_reg;
         if (run && !non_configured) begin
            booted_msg_reg <= 1'b1;
         end
      end
   end

   // ****************************************
   // persistence of assigned values
   // ****************************************
   // a value set in the nv_ack cycle of a write is written again: set wins over clear
   logic pend_node_reg, pend_rate_reg, wr_is_node_reg;
   logic tbl_node_store, tbl_rate_store;
   assign tbl_node_store = (state_reg == ST_DECIDE) && (sw_s2_reg == sw_s3_reg) && node_from_table;
   assign tbl_rate_store = (state_reg == ST_DECIDE) && (sw_s2_reg == sw_s3_reg) && rate_from_table;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_node_reg <= 1'b0;
         pend_rate_reg <= 1'b0;
         wr_is_node_reg <= 1'b0;
      end else begin
         if (tbl_node_store || lss_node_take || serial_take) begin
            pend_node_reg <= 1'b1;
         end else if (nv_wr && nv_ack && wr_is_node_reg) begin
            pend_node_reg <= 1'b0;
         end
         if (tbl_rate_store || lss_rate_take) begin
            pend_rate_reg <= 1'b1;
         end else if (nv_wr && nv_ack && !wr_is_node_reg) begin
            pend_rate_reg <= 1'b0;
         end
         if (run && !nv_wr) begin
            wr_is_node_reg <= pend_node_reg;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nv_rd <= 1'b0;
         nv_wr <= 1'b0;
         nv_addr <= 3'h0;
         nv_wdata <= 16'h0000;
      end else begin
         nv_rd <= (state_reg == ST_LOAD_REQ) || (state_reg == ST_LOAD_WAIT && !nv_ack);
         if (state_reg == ST_LOAD_REQ) begin
            nv_addr <= idx_reg;
         end
         if (nv_wr) begin
            nv_wr <= !nv_ack;
         end else if (run && (pend_node_reg || pend_rate_reg)) begin
            nv_wr <= 1'b1;
            if (pend_node_reg) begin
               nv_addr <= `IDX_LAST_NODE;
               nv_wdata <= {1'b1, 7'h00, node_number};
            end else begin
               nv_addr <= `IDX_LAST_RATE;
               nv_wdata <= {1'b1, 12'h000, 1'b0, can_rate};
            end
         end
      end
   end

   // ****************************************
   // apb slave
   // ****************************************
   // two access cycles for every transfer so the ram window reads through a register
   logic apb_commit, ram_hit, map_hit;
   assign apb_commit = psel && penable && pready;
   assign ram_hit = (paddr >= `REG_RAM_BASE) && (paddr <= `REG_RAM_TOP) && (paddr[1:0] == 2'h0);
   assign map_hit = ram_hit || paddr == `REG_STATUS || paddr == `REG_NODE
                    || paddr == `REG_RATE || paddr == `REG_SERIAL_NODE;
   assign serial_wr = run && apb_commit && pwrite && (paddr == `REG_SERIAL_NODE);
   assign serial_node = pwdata[7:0];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !map_hit;
         if (psel && penable && !pready && !pwrite) begin
            if (ram_hit) begin
               // the ram port belongs to the boot sequence until it ends
               prdata <= run ? {16'h0000, ram_rdata} : 32'h0000_0000;
            end else begin
               case (paddr)
                  `REG_STATUS: prdata <= {26'h000_0000, table_valid_reg,
                     pend_node_reg | pend_rate_reg, non_configured, canopen_mode, run, boot_done};
                  `REG_NODE: prdata <= {24'h00_0000, node_number};
                  `REG_RATE: prdata <= {30'h0000_0000, can_rate};
                  default: prdata <= 32'h0000_0000;
               endcase
            end
         end
      end
   end
endmodule : node_id_and_bitrate_boot_loader

// ### verification/boot_loader_sva.sv
// assertions on the ports of the boot loader
// assumes one pclk domain with presetn low clearing everything
`timescale 1ns/100ps
module boot_loader_sva (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // nonvolatile memory
   input wire logic nv_rd,
   input wire logic nv_wr,
   input wire logic [2:0] nv_addr,
   input wire logic nv_ack,
   // network side
   input wire logic lss_node_valid,
   input wire logic lss_rate_valid,
   input wire logic [1:0] lss_rate,
   input wire logic cmd_valid,
   input wire logic cmd_is_lss,
   input wire logic cmd_accept,
   input wire logic tx_enable,
   input wire logic bootup_send,
   // selection
   input wire logic [7:0] node_number,
   input wire boot_loader_pkg::rate_t can_rate,
   input wire logic canopen_mode,
   input wire logic non_configured,
   input wire logic boot_done
);
   import boot_loader_pkg::*;
   logic [2:0] last_rd_reg;
   logic rd_seen_reg;
   // ****************
   // read order tracker
   // ****************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_rd_reg <= 3'h0;
         rd_seen_reg <= 1'b0;
      end else if (nv_rd && nv_ack) begin
         last_rd_reg <= nv_addr;
         rd_seen_reg <= 1'b1;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence apb_setup; psel && !penable; endsequence
   sequence apb_access; psel && penable; endsequence
   pready_timing_a: assert property (apb_setup |=> ((apb_access and !pready) ##1 pready))
      else $error("pready not in second access cycle");
   unmapped_err_a: assert property (pready && (paddr inside {[8'h10:8'h1c]} || paddr > 8'h3c)
      |-> pslverr && prdata == 32'h0000_0000) else $error("unmapped access not refused");
   nv_hold_a: assert property ((nv_rd || nv_wr) && !nv_ack |=> (nv_rd || nv_wr) && $stable(nv_addr))
      else $error("memory request dropped early");
   nv_order_a: assert property ($rose(nv_rd) && !boot_done
      |-> nv_addr == (rd_seen_reg ? last_rd_reg + 3'h1 : 3'h0)) else $error("table read order");
   nv_write_a: assert property ($rose(nv_wr) |-> boot_done && nv_addr[2:1] == 2'b11)
      else $error("memory write outside run or slots");
   canopen_cap_a: assert property (boot_done && canopen_mode |-> node_number <= 8'h7f
      || (node_number == 8'hff && non_configured)) else $error("canopen node not capped");
   quiet_tx_a: assert property (non_configured && $past(non_configured)
      |-> !tx_enable && !bootup_send) else $error("transmit while non-configured");
   cmd_refuse_a: assert property (cmd_valid && non_configured && !cmd_is_lss |=> !cmd_accept)
      else $error("command taken while non-configured");
   cmd_take_a: assert property (cmd_valid && boot_done && (cmd_is_lss || !non_configured)
      |=> cmd_accept) else $error("command not accepted");
   rate_lss_a: assert property (boot_done && lss_rate_valid |=> can_rate == $past(lss_rate))
      else $error("assigned rate not applied");
   node_steady_a: assert property (boot_done && $past(boot_done) && !lss_node_valid
      && !$past(lss_node_valid) && !psel && !$past(psel)
      |=> $stable(node_number) && $stable(canopen_mode)) else $error("node changed unasked");
endmodule : boot_loader_sva

bind node_id_and_bitrate_boot_loader boot_loader_sva checker_i (.pclk, .presetn, .psel,
   .penable, .paddr, .prdata, .pready, .pslverr, .nv_rd, .nv_wr, .nv_addr, .nv_ack,
   .lss_node_valid, .lss_rate_valid, .lss_rate, .cmd_valid, .cmd_is_lss, .cmd_accept,
   .tx_enable, .bootup_send, .node_number, .can_rate, .canopen_mode, .non_configured,
   .boot_done);

// ### verification/nv_memory_model.sv
// nonvolatile memory model facing the boot loader
// assumes requests held until nv_ack; bench preloads mem by hierarchy
`timescale 1ns/100ps
module nv_memory_model (
   // clock
   input wire logic pclk,
   // memory port
   input wire logic nv_rd,
   input wire logic nv_wr,
   input wire logic [2:0] nv_addr,
   input wire logic [15:0] nv_wdata,
   output logic nv_ack,
   output logic [15:0] nv_rdata,
   // extra wait cycles per access
   input wire logic [1:0] latency
);
   logic [15:0] mem [0:7]; // 16-bit words at ascending addresses
   logic [1:0] wait_reg;
   initial begin
      nv_ack = 1'b0;
      nv_rdata = 16'h0000;
      wait_reg = 2'h0;
   end
   always @(posedge pclk) begin
      nv_ack <= 1'b0;
      nv_rdata <= ~nv_rdata; // data only valid with the ack
      if ((nv_rd || nv_wr) && !nv_ack) begin
         if (wait_reg == latency) begin
            nv_ack <= 1'b1;
            wait_reg <= 2'h0;
            if (nv_wr) begin
               mem[nv_addr] <= nv_wdata; // survives resets
            end else begin
               nv_rdata <= mem[nv_addr];
            end
         end else begin
            wait_reg <= wait_reg + 2'h1;
         end
      end
   end
endmodule : nv_memory_model

// ### verification/testbench.sv
// self-checking bench of the node number and bit rate boot loader
// assumes the memory model and the bound checker
`timescale 1ns/100ps
`include "boot_loader_defs.svh"
module testbench;
   import boot_loader_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, identity_switch_bank = 8'h00, lss_node = 8'h00, sw_cur;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic pready, pslverr, nv_rd, nv_wr, nv_ack, cmd_accept, tx_enable, bootup_send;
   logic lss_node_valid = 1'b0, lss_rate_valid = 1'b0, cmd_valid = 1'b0, cmd_is_lss = 1'b0;
   logic [1:0] lss_rate = 2'h0, latency = 2'h0;
   logic [2:0] nv_addr;
   logic [15:0] nv_wdata, nv_rdata;
   logic [15:0] tbl [8];
   logic [7:0] node_number;
   rate_t can_rate;
   logic canopen_mode, non_configured, boot_done, err, acc;
   logic [31:0] rd;
   int bad_count = 0, n_compared = 0, k;
   always #50 pclk = ~pclk;
   node_id_and_bitrate_boot_loader DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .identity_switch_bank, .nv_rd, .nv_wr, .nv_addr,
      .nv_wdata, .nv_ack, .nv_rdata, .lss_node_valid, .lss_node, .lss_rate_valid, .lss_rate,
      .cmd_valid, .cmd_is_lss, .cmd_accept, .tx_enable, .bootup_send, .node_number,
      .can_rate, .canopen_mode, .non_configured, .boot_done);
   nv_memory_model nv (.pclk, .nv_rd, .nv_wr, .nv_addr, .nv_wdata, .nv_ack, .nv_rdata,
      .latency);
   // ****************
   // expectations and checks
   // ****************
   function automatic logic [7:0] pick_node();
      logic [7:0] n;
      n = (tbl[6][15]) ? tbl[6][7:0] : 8'h00;
      if (tbl[0] == `SETUP_MARK && tbl[1][0]) n = tbl[2][7:0];
      if (n == 8'h00) n = {1'b0, sw_cur[7:1]};
      if (sw_cur[0] && n > 8'h7f) n = 8'hff;
      return n;
   endfunction : pick_node
   function automatic logic [1:0] pick_rate();
      if (tbl[0] == `SETUP_MARK && tbl[1][1]) return (tbl[3][2]) ? 2'h2 : tbl[3][1:0];
      return (tbl[7][15]) ? tbl[7][1:0] : 2'h2;
   endfunction : pick_rate
   task automatic stop_test;
      if (bad_count == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : check
   task automatic timed_out;
      check(0, 1, "wait ran out");
      stop_test();
   endtask : timed_out
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16 && pready !== 1'b1; i++) @(posedge pclk);
      if (pready !== 1'b1) timed_out();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic pulse(input logic [1:0] kind, input logic [7:0] v);
      @(posedge pclk);
      cmd_valid <= kind == 2'h0;
      cmd_is_lss <= v[0];
      lss_rate_valid <= kind == 2'h1;
      lss_rate <= v[1:0];
      lss_node_valid <= kind == 2'h2;
      lss_node <= v;
      @(posedge pclk);
      {cmd_valid, lss_rate_valid, lss_node_valid} <= 3'b000;
      @(posedge pclk);
      acc = cmd_accept;
   endtask : pulse
   task automatic boot(input logic [7:0] sw);
      int i;
      presetn <= 1'b0;
      sw_cur = sw;
      identity_switch_bank <= sw;
      latency <= 2'($urandom_range(3));
      @(posedge pclk);
      for (i = 0; i < 8; i++) nv.mem[i] = tbl[i];
      repeat (19) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 600 && boot_done !== 1'b1; i++) @(posedge pclk);
      if (boot_done !== 1'b1) timed_out();
      apb(1'b0, `REG_RAM_BASE + 8'h08, 32'h0000_0000);
      check(rd[15:0], tbl[2], "ram copy");
      check(node_number, pick_node(), "node number");
      check(can_rate, pick_rate(), "bit rate");
      check(canopen_mode, sw[0], "mode");
      check(non_configured, sw[0] && pick_node() == 8'hff, "non-configured");
      check(tx_enable, !(sw[0] && pick_node() == 8'hff), "transmit gate");
   endtask : boot
   initial begin
      k = $urandom(76);
      tbl = '{`SETUP_MARK, 16'h0003, 16'h00c8, 16'h0001, 16'h0, 16'h0, 16'h0, 16'h0};
      boot(8'h55);
      pulse(2'h0, 8'h00);
      check(acc, 1'b0, "plain command taken");
      pulse(2'h0, 8'h01);
      check(acc, 1'b1, "layer command refused");
      apb(1'b1, `REG_SERIAL_NODE, 32'h0000_0080);
      check(node_number, 8'hff, "serial node above 127");
      apb(1'b1, `REG_SERIAL_NODE, 32'h0000_0005);
      check({node_number, non_configured}, {8'h05, 1'b0}, "serial node");
      pulse(2'h0, 8'h00);
      check(acc, 1'b1, "command after config");
      apb(1'b1, `REG_NODE, 32'h0000_00aa);
      check(node_number, 8'h05, "read-only node written");
      apb(1'b0, 8'h14, 32'h0000_0000);
      check({err, rd}, {1'b1, 32'h0000_0000}, "unmapped read");
      for (k = 0; k < 300 && nv.mem[6] !== 16'h8005; k++) @(posedge pclk);
      check(nv.mem[6], 16'h8005, "persisted node");
      tbl[0] = 16'h0000;
      tbl[6] = nv.mem[6];
      tbl[7] = nv.mem[7];
      boot(8'h55);
      for (k = 0; k < 4; k++) begin
         pulse(2'h1, 8'(k));
         check(can_rate, k, "assigned rate");
      end
      pulse(2'h2, 8'h33);
      check(node_number, 8'h33, "assigned node");
      for (k = 0; k < 10; k++) begin
         tbl[0] = ($urandom_range(3) != 0) ? `SETUP_MARK : 16'($urandom);
         tbl[1] = 16'($urandom_range(3));
         tbl[2] = 16'($urandom_range(255));
         tbl[3] = 16'($urandom_range(7));
         tbl[6] = {1'($urandom_range(1)), 7'h00, 8'($urandom)};
         tbl[7] = {1'($urandom_range(1)), 13'h0000, 2'($urandom)};
         boot(8'($urandom));
      end
      stop_test();
   end
endmodule : testbench
